//--- qxr_flash_cmd.sv
// Purpose: device-side command interpreter for register commands and execute-in-place reads
// Assumes: serial clock, select and data lines are asynchronous; sampled by I_CLK, mode 0 framing
// Notes: APB answers after one wait state; all state but the reset synchroniser held in one struct
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
module qxr_flash_cmd #(
  parameter int unsigned DUMMY_CYC = qxr_pkg::DUMMY_CYC_DEF
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_S_B,
  input wire logic I_SCLK,
  input wire logic I_WP_B,
  input wire logic [3:0] I_DQ,
  output logic [3:0] O_DQ,
  output logic [3:0] O_DQ_OE
);
  // =====================================================================
  // parameter check
  if (DUMMY_CYC < 2 || DUMMY_CYC > 15) begin : g_bad_dummy
    $error("DUMMY_CYC must be 2..15");
  end

  // =====================================================================
  // reset release
  logic [1:0] rst_sync_ff;
  logic rst_b;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_sync_ff <= 2'h0;
    end else if (I_CE) begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_ff[1];

  // =====================================================================
  // link events
  qxr_pkg::qxr_state_t s_ff;
  qxr_pkg::qxr_state_t nxt_s;
  logic sc_rise, sc_fall, cs_fall, cs_rise, sel;
  logic apb_acc, apb_wr;
  logic ev_sr_wr, ev_lk_wr, ev_nv_wr, ev_vc_wr, ev_clf, ev_conf, ev_resc_done;
  logic [4:0] resc_len;

  assign sc_rise = s_ff.sc_sync[1] & ~s_ff.sc_sync[2];
  assign sc_fall = ~s_ff.sc_sync[1] & s_ff.sc_sync[2];
  assign cs_fall = ~s_ff.sb_sync[1] & s_ff.sb_sync[2];
  assign cs_rise = s_ff.sb_sync[1] & ~s_ff.sb_sync[2];
  assign sel = ~s_ff.sb_sync[1];
  assign apb_acc = I_PSEL & I_PENABLE;
  assign apb_wr = I_CE & apb_acc & I_PWRITE & s_ff.pready;
  assign ev_sr_wr = I_CE & cs_rise & s_ff.din_done & (s_ff.opc == qxr_pkg::OP_SR_WR);
  assign ev_lk_wr = I_CE & cs_rise & s_ff.din_done & (s_ff.opc == qxr_pkg::OP_LK_WR);
  assign ev_nv_wr = I_CE & cs_rise & s_ff.din_done & (s_ff.opc == qxr_pkg::OP_NV_WR);
  assign ev_vc_wr = I_CE & cs_rise & s_ff.din_done & (s_ff.opc == qxr_pkg::OP_VC_WR);
  assign ev_clf = I_CE & cs_rise & (s_ff.st == qxr_pkg::ST_IGN) & (s_ff.opc == qxr_pkg::OP_FL_CLR);
  assign ev_conf = I_CE & sel & sc_rise & (s_ff.st == qxr_pkg::ST_DUMMY) & (s_ff.dcnt == 4'h0);
  assign resc_len = (s_ff.resc_stage == 2'h0) ? qxr_pkg::RESC_LEN0 :
                    (s_ff.resc_stage == 2'h1) ? qxr_pkg::RESC_LEN1 : qxr_pkg::RESC_LEN2;
  assign ev_resc_done = I_CE & cs_rise & s_ff.resc_hi & (s_ff.resc_cnt == resc_len) & (s_ff.resc_stage == 2'h2);

  // =====================================================================
  // helpers
  function automatic logic [2:0] proto_lines(input logic [1:0] p);
    case (p)
      qxr_pkg::PROTO_QUAD: proto_lines = 3'h4;
      qxr_pkg::PROTO_DUAL: proto_lines = 3'h2;
      default: proto_lines = 3'h1;
    endcase
  endfunction

  function automatic logic [15:0] out_val(input qxr_pkg::qxr_state_t st);
    case (st.opc)
      qxr_pkg::OP_SR_RD: out_val = {2{st.sr[7:2], st.write_enable_latch, 1'b0}};
      qxr_pkg::OP_LK_RD: out_val = {2{st.lock}};
      qxr_pkg::OP_FL_RD: out_val = {2{st.flag}};
      qxr_pkg::OP_NV_RD: out_val = st.nvcfg;
      qxr_pkg::OP_VC_RD: out_val = {2{st.vcfg}};
      qxr_pkg::OP_EC_RD: out_val = {2{st.evcfg}};
      default: out_val = {2{st.rdata}};
    endcase
  endfunction

  function automatic logic is_fast(input logic [7:0] op);
    is_fast = (op == qxr_pkg::OP_FAST_RD) || (op == qxr_pkg::OP_DUAL_RD) || (op == qxr_pkg::OP_QUAD_RD);
  endfunction

  // =====================================================================
  // next state
  always_comb begin
    logic [23:0] sh;
    logic [4:0] bnext;
    logic [4:0] need;
    logic [3:0] onext;
    logic xip_en;
    sh = '0;
    bnext = '0;
    need = '0;
    onext = '0;
    xip_en = 1'b0;
    nxt_s = s_ff;
    nxt_s.sb_sync = {s_ff.sb_sync[1:0], I_S_B};
    nxt_s.sc_sync = {s_ff.sc_sync[1:0], I_SCLK};
    nxt_s.dq_s1 = I_DQ;
    nxt_s.dq_s2 = s_ff.dq_s1;
    nxt_s.wp_sync = {s_ff.wp_sync[0], I_WP_B};
    case (s_ff.lines)
      3'h4: sh = {s_ff.shreg[19:0], s_ff.dq_s2};
      3'h2: sh = {s_ff.shreg[21:0], s_ff.dq_s2[1:0]};
      default: sh = {s_ff.shreg[22:0], s_ff.dq_s2[0]};
    endcase
    bnext = s_ff.bitcnt + {2'h0, s_ff.lines};
    need = (s_ff.opc == qxr_pkg::OP_NV_WR) ? 5'h10 : 5'h08;
    xip_en = ~s_ff.vcfg[qxr_pkg::VC_XIP_BIT] | s_ff.basic;
    if (cs_fall) begin
      nxt_s.st = s_ff.execute_in_place_mode ? qxr_pkg::ST_ADDR : qxr_pkg::ST_CMD;
      nxt_s.opc = s_ff.execute_in_place_mode ? qxr_pkg::OP_FAST_RD : s_ff.opc;
      nxt_s.lines = s_ff.execute_in_place_mode ? s_ff.xip_lines : proto_lines(s_ff.proto);
      nxt_s.bitcnt = 5'h0;
      nxt_s.din_done = 1'b0;
      nxt_s.resc_cnt = 5'h0;
      nxt_s.resc_hi = 1'b1;
    end else if (sel && sc_rise) begin
      nxt_s.resc_cnt = (s_ff.resc_cnt == 5'h1f) ? s_ff.resc_cnt : s_ff.resc_cnt + 5'h1;
      nxt_s.resc_hi = s_ff.resc_hi & s_ff.dq_s2[0];
      case (s_ff.st)
        qxr_pkg::ST_CMD: begin
          nxt_s.shreg = sh;
          nxt_s.bitcnt = bnext;
          if (bnext == 5'h08) begin
            nxt_s.opc = sh[7:0];
            nxt_s.bitcnt = 5'h0;
            case (sh[7:0])
              qxr_pkg::OP_SR_RD, qxr_pkg::OP_FL_RD, qxr_pkg::OP_NV_RD, qxr_pkg::OP_VC_RD,
              qxr_pkg::OP_EC_RD: nxt_s.st = qxr_pkg::ST_OUT;
              qxr_pkg::OP_LK_RD, qxr_pkg::OP_LK_WR: nxt_s.st = qxr_pkg::ST_ADDR;
              qxr_pkg::OP_FAST_RD: nxt_s.st = qxr_pkg::ST_ADDR;
              qxr_pkg::OP_DUAL_RD: begin
                nxt_s.st = qxr_pkg::ST_ADDR;
                nxt_s.lines = (s_ff.proto == qxr_pkg::PROTO_EXT) ? 3'h2 : s_ff.lines;
              end
              qxr_pkg::OP_QUAD_RD: begin
                nxt_s.st = qxr_pkg::ST_ADDR;
                nxt_s.lines = (s_ff.proto == qxr_pkg::PROTO_EXT) ? 3'h4 : s_ff.lines;
              end
              qxr_pkg::OP_SR_WR, qxr_pkg::OP_NV_WR, qxr_pkg::OP_VC_WR,
              qxr_pkg::OP_EC_WR: nxt_s.st = qxr_pkg::ST_DIN;
              default: nxt_s.st = qxr_pkg::ST_IGN;
            endcase
            nxt_s.obuf = out_val('{default: '0, opc: sh[7:0], sr: s_ff.sr, write_enable_latch: s_ff.write_enable_latch, lock: s_ff.lock,
              flag: s_ff.flag, nvcfg: s_ff.nvcfg, vcfg: s_ff.vcfg, evcfg: s_ff.evcfg, rdata: s_ff.rdata,
              st: qxr_pkg::ST_CMD});
            nxt_s.ocnt = 4'h0;
          end
        end
        qxr_pkg::ST_ADDR: begin
          nxt_s.shreg = sh;
          nxt_s.bitcnt = bnext;
          if (bnext == 5'h18) begin
            nxt_s.addr = sh;
            nxt_s.bitcnt = 5'h0;
            nxt_s.dcnt = 4'h0;
            nxt_s.ocnt = 4'h0;
            nxt_s.obuf = out_val(s_ff);
            if (is_fast(s_ff.opc)) begin
              nxt_s.st = qxr_pkg::ST_DUMMY;
            end else if (s_ff.opc == qxr_pkg::OP_LK_WR) begin
              nxt_s.st = qxr_pkg::ST_DIN;
            end else begin
              nxt_s.st = qxr_pkg::ST_OUT;
            end
          end
        end
        qxr_pkg::ST_DUMMY: begin
          if (s_ff.dcnt == 4'h0) begin
            // only line zero carries the confirmation
            if (s_ff.dq_s2[0]) begin
              nxt_s.execute_in_place_mode = 1'b0;
            end else if (xip_en || s_ff.execute_in_place_mode) begin
              nxt_s.execute_in_place_mode = 1'b1;
              nxt_s.xip_lines = s_ff.lines;
            end
          end
          nxt_s.dcnt = s_ff.dcnt + 4'h1;
          if (s_ff.dcnt == 4'(DUMMY_CYC - 1)) begin
            nxt_s.st = qxr_pkg::ST_OUT;
            nxt_s.obuf = {2{s_ff.rdata}};
            nxt_s.ocnt = 4'h0;
          end
        end
        qxr_pkg::ST_DIN: begin
          nxt_s.shreg = sh;
          nxt_s.bitcnt = bnext;
          if (bnext == need) begin
            nxt_s.din_done = 1'b1;
            nxt_s.st = qxr_pkg::ST_IGN;
          end
        end
        qxr_pkg::ST_OUT, qxr_pkg::ST_IGN: begin
        end
        default: nxt_s.st = qxr_pkg::ST_IGN;
      endcase
    end
    // output shifter: new bits after each falling edge
    if (!sel || cs_rise) begin
      nxt_s.dq_oe = 4'h0;
    end else if (sc_fall && s_ff.st == qxr_pkg::ST_OUT) begin
      onext = s_ff.ocnt + {1'b0, s_ff.lines};
      case (s_ff.lines)
        3'h4: begin
          nxt_s.dq_out = s_ff.obuf[15:12];
          nxt_s.dq_oe = 4'hf;
          nxt_s.obuf = {s_ff.obuf[11:0], 4'h0};
        end
        3'h2: begin
          nxt_s.dq_out = {2'h0, s_ff.obuf[15:14]};
          nxt_s.dq_oe = 4'h3;
          nxt_s.obuf = {s_ff.obuf[13:0], 2'h0};
        end
        default: begin
          nxt_s.dq_out = {2'h0, s_ff.obuf[15], 1'b0};
          nxt_s.dq_oe = 4'h2;
          nxt_s.obuf = {s_ff.obuf[14:0], 1'b0};
        end
      endcase
      nxt_s.ocnt = onext;
      if (onext == 4'h0) begin
        nxt_s.obuf = out_val(s_ff);
      end
    end
    // frame end actions
    if (cs_rise) begin
      if (s_ff.st == qxr_pkg::ST_IGN && s_ff.opc == qxr_pkg::OP_WEN) begin
        nxt_s.write_enable_latch = 1'b1;
        nxt_s.fast_por = 1'b0;
      end
      if (s_ff.st == qxr_pkg::ST_IGN && s_ff.opc == qxr_pkg::OP_WDIS) begin
        nxt_s.write_enable_latch = 1'b0;
      end
      if (ev_clf) begin
        nxt_s.flag = s_ff.flag & ~qxr_pkg::FL_ERR_MASK;
      end
      if (ev_sr_wr && s_ff.write_enable_latch && !s_ff.hwprot) begin
        nxt_s.sr = {s_ff.shreg[7:2], 2'h0};
        nxt_s.write_enable_latch = 1'b0;
        if (s_ff.proto == qxr_pkg::PROTO_QUAD && s_ff.shreg[qxr_pkg::SR_WDIS_BIT]) begin
          nxt_s.hwprot = 1'b1;
        end
      end
      if (ev_lk_wr && s_ff.write_enable_latch) begin
        nxt_s.lock = s_ff.shreg[7:0];
        nxt_s.write_enable_latch = 1'b0;
      end
      if (ev_nv_wr && s_ff.write_enable_latch) begin
        nxt_s.nvcfg = s_ff.shreg[15:0];
        nxt_s.write_enable_latch = 1'b0;
      end
      if (ev_vc_wr && (s_ff.write_enable_latch || s_ff.fast_por)) begin
        nxt_s.vcfg = s_ff.shreg[7:0];
        nxt_s.write_enable_latch = 1'b0;
      end
      if (s_ff.din_done && s_ff.opc == qxr_pkg::OP_EC_WR && (s_ff.write_enable_latch || s_ff.fast_por)) begin
        nxt_s.evcfg = s_ff.shreg[7:0];
        nxt_s.write_enable_latch = 1'b0;
      end
      // rescue: consecutive selections of exact length with line zero high
      if (s_ff.resc_hi && s_ff.resc_cnt == resc_len) begin
        nxt_s.resc_stage = (s_ff.resc_stage == 2'h2) ? 2'h0 : s_ff.resc_stage + 2'h1;
        if (s_ff.resc_stage == 2'h2) begin
          nxt_s.execute_in_place_mode = 1'b0;
        end
      end else begin
        nxt_s.resc_stage = (s_ff.resc_hi && s_ff.resc_cnt == qxr_pkg::RESC_LEN0) ? 2'h1 : 2'h0;
      end
    end
    // =====================================================================
    // apb slave
    nxt_s.pready = 1'b0;
    nxt_s.pslverr = 1'b0;
    if (apb_acc && !s_ff.pready) begin
      nxt_s.pready = 1'b1;
      nxt_s.pslverr = 1'b0;
      case (I_PADDR)
        qxr_pkg::A_CTRL: nxt_s.prdata = {29'h0, s_ff.basic, s_ff.proto};
        qxr_pkg::A_STAT: nxt_s.prdata = {25'h0, s_ff.fast_por, s_ff.xip_lines, s_ff.execute_in_place_mode, s_ff.hwprot, s_ff.write_enable_latch};
        qxr_pkg::A_SR: nxt_s.prdata = {24'h0, s_ff.sr[7:2], s_ff.write_enable_latch, 1'b0};
        qxr_pkg::A_FLAG: nxt_s.prdata = {24'h0, s_ff.flag};
        qxr_pkg::A_LOCK: nxt_s.prdata = {24'h0, s_ff.lock};
        qxr_pkg::A_NVCFG: nxt_s.prdata = {16'h0, s_ff.nvcfg};
        qxr_pkg::A_VCFG: nxt_s.prdata = {24'h0, s_ff.vcfg};
        qxr_pkg::A_EVCFG: nxt_s.prdata = {24'h0, s_ff.evcfg};
        qxr_pkg::A_DATA: nxt_s.prdata = {24'h0, s_ff.rdata};
        qxr_pkg::A_ADDR: nxt_s.prdata = {8'h0, s_ff.addr};
        default: begin
          nxt_s.prdata = 32'h0;
          nxt_s.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_acc && I_PWRITE && s_ff.pready) begin
      case (I_PADDR)
        qxr_pkg::A_CTRL: begin
          nxt_s.proto = I_PWDATA[1:0];
          nxt_s.basic = I_PWDATA[qxr_pkg::CTRL_BASIC_BIT];
          if (I_PWDATA[qxr_pkg::CTRL_POR_BIT]) begin
            // power-on sequence: volatile state back to defaults
            nxt_s.write_enable_latch = 1'b0;
            nxt_s.vcfg = qxr_pkg::VCFG_RST;
            nxt_s.evcfg = qxr_pkg::EVCFG_RST;
            nxt_s.fast_por = s_ff.nvcfg[qxr_pkg::NV_FPOR_BIT];
            nxt_s.xip_lines = qxr_pkg::xip_lines_of(s_ff.nvcfg[11:9]);
            nxt_s.execute_in_place_mode = (qxr_pkg::xip_lines_of(s_ff.nvcfg[11:9]) != 3'h0);
            nxt_s.lock = 8'h00;
          end
        end
        qxr_pkg::A_FLAG: nxt_s.flag = nxt_s.flag | I_PWDATA[7:0];
        qxr_pkg::A_DATA: nxt_s.rdata = I_PWDATA[7:0];
        default: begin
        end
      endcase
    end
    // single-line protocol: protection follows the pin again
    if (nxt_s.proto == qxr_pkg::PROTO_EXT) begin
      nxt_s.hwprot = nxt_s.sr[qxr_pkg::SR_WDIS_BIT] & ~s_ff.wp_sync[1];
    end
  end

  always_ff @(posedge I_CLK or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= qxr_pkg::QXR_RST;
    end else if (I_CE) begin
      s_ff <= nxt_s;
    end
  end

  assign O_PRDATA = s_ff.prdata;
  assign O_PREADY = s_ff.pready;
  assign O_PSLVERR = s_ff.pslverr;
  assign O_DQ = s_ff.dq_out;
  assign O_DQ_OE = s_ff.dq_oe;

  // =====================================================================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!rst_b);

  sequence s_conf_one;
    ev_conf ##0 s_ff.dq_s2[0] ##0 !apb_wr;
  endsequence
  sequence s_xip_select;
    I_CE ##0 cs_fall ##0 s_ff.execute_in_place_mode;
  endsequence

  a_sr_wr_gate: assert property (ev_sr_wr && (!s_ff.write_enable_latch || s_ff.hwprot) |=> $stable(s_ff.sr))
    else $error("status write taken without latch");
  a_prot_entry: assert property (ev_sr_wr && s_ff.write_enable_latch && !s_ff.hwprot && s_ff.shreg[7] && !apb_wr
    && s_ff.proto == qxr_pkg::PROTO_QUAD |=> s_ff.hwprot && s_ff.sr[7])
    else $error("status_write_disable_bit write did not protect");
  a_lock_wr_gate: assert property (ev_lk_wr && !s_ff.write_enable_latch && !apb_wr |=> $stable(s_ff.lock))
    else $error("lock changed without latch");
  a_flag_clear: assert property (ev_clf && !apb_wr |=> (s_ff.flag & qxr_pkg::FL_ERR_MASK) == 8'h00)
    else $error("error flags not cleared");
  a_clf_wel_kept: assert property (ev_clf && !apb_wr |=> s_ff.write_enable_latch == $past(s_ff.write_enable_latch))
    else $error("flag clear touched latch");
  a_nv_wr_gate: assert property (ev_nv_wr && !s_ff.write_enable_latch |=> $stable(s_ff.nvcfg))
    else $error("nv config written without latch");
  a_vc_fast_por: assert property (ev_vc_wr && s_ff.fast_por && !apb_wr
    |=> s_ff.vcfg == $past(s_ff.shreg[7:0]) && !s_ff.write_enable_latch)
    else $error("quick power-on volatile write lost");
  a_conf_exit: assert property (s_conf_one |=> !s_ff.execute_in_place_mode ##1 !s_ff.execute_in_place_mode || !cs_fall)
    else $error("confirmation one kept xip");
  a_xip_readdr: assert property (s_xip_select |=> s_ff.st == qxr_pkg::ST_ADDR && s_ff.bitcnt == 5'h0)
    else $error("xip selection did not start with address");
  a_rescue_exit: assert property (ev_resc_done && !apb_wr |=> !s_ff.execute_in_place_mode && s_ff.resc_stage == 2'h0)
    else $error("rescue did not leave xip");
endmodule // qxr_flash_cmd

//--- qxr_host_model.sv
// Purpose: host controller model for the serial link
// Assumes: mode 0, 64 ns serial clock, four lines a clock
// Notes: released lines carry a changing pattern
`timescale 1ns/100ps
module qxr_host_model (
  output logic o_s_b,
  output logic o_sclk,
  output logic [3:0] o_dq,
  input wire logic [3:0] i_dq
);
  int sd = 32'h5b82;
  initial begin
    o_s_b = 1'b1;
    o_sclk = 1'b0;
    o_dq = 4'h0;
  end
  // =====================================
  // one frame, msb nibble first
  task automatic frame(input logic [63:0] tx, input int n, nd, output logic [63:0] rx);
    rx = '0;
    #3 o_s_b = 1'b0;
    for (int k = 0; k < n; k++) begin
      o_dq = (k < nd) ? tx[63 - 4 * (k % 16) -: 4] : 4'($random(sd));
      #32 o_sclk = 1'b1;
      rx = {rx[59:0], i_dq};
      #32 o_sclk = 1'b0;
    end
    #32 o_s_b = 1'b1;
    o_dq = ~o_dq;
    #64;
  endtask
endmodule // qxr_host_model

//--- qxr_pkg.sv
// Purpose: constants, types and reset values for the serial flash register-command and execute-in-place block
// Assumes: 125 MHz system clock samples the serial link; software reaches registers over APB
// Notes: opcodes and configuration field codes are local encodings
// =====================================================================
package qxr_pkg;
  // =====================================================================
  // opcodes
  localparam logic [7:0] OP_FAST_RD = 8'h0b;
  localparam logic [7:0] OP_DUAL_RD = 8'h3b;
  localparam logic [7:0] OP_QUAD_RD = 8'heb;
  localparam logic [7:0] OP_SR_RD = 8'h41;
  localparam logic [7:0] OP_SR_WR = 8'h42;
  localparam logic [7:0] OP_LK_RD = 8'h43;
  localparam logic [7:0] OP_LK_WR = 8'h44;
  localparam logic [7:0] OP_FL_RD = 8'h45;
  localparam logic [7:0] OP_FL_CLR = 8'h46;
  localparam logic [7:0] OP_NV_RD = 8'h47;
  localparam logic [7:0] OP_NV_WR = 8'h48;
  localparam logic [7:0] OP_VC_RD = 8'h49;
  localparam logic [7:0] OP_VC_WR = 8'h4a;
  localparam logic [7:0] OP_EC_RD = 8'h4b;
  localparam logic [7:0] OP_EC_WR = 8'h4c;
  localparam logic [7:0] OP_WEN = 8'h4d;
  localparam logic [7:0] OP_WDIS = 8'h4e;
  // =====================================================================
  // protocols, fields, timing
  localparam logic [1:0] PROTO_EXT = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;
  localparam int unsigned DUMMY_CYC_DEF = 8;
  localparam int unsigned VC_XIP_BIT = 3;
  localparam int unsigned NV_FPOR_BIT = 5;
  localparam int unsigned SR_WDIS_BIT = 7;
  localparam logic [2:0] NV_XIP_SINGLE = 3'h1;
  localparam logic [2:0] NV_XIP_DUAL = 3'h2;
  localparam logic [2:0] NV_XIP_QUAD = 3'h4;
  localparam logic [7:0] FL_ERR_MASK = 8'h3a;
  localparam logic [4:0] RESC_LEN0 = 5'h07;
  localparam logic [4:0] RESC_LEN1 = 5'h0d;
  localparam logic [4:0] RESC_LEN2 = 5'h19;
  localparam logic [15:0] NVCFG_RST = 16'hffdf;
  localparam logic [7:0] VCFG_RST = 8'hfb;
  localparam logic [7:0] EVCFG_RST = 8'hff;
  // =====================================================================
  // apb map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_SR = 8'h08;
  localparam logic [7:0] A_FLAG = 8'h0c;
  localparam logic [7:0] A_LOCK = 8'h10;
  localparam logic [7:0] A_NVCFG = 8'h14;
  localparam logic [7:0] A_VCFG = 8'h18;
  localparam logic [7:0] A_EVCFG = 8'h1c;
  localparam logic [7:0] A_DATA = 8'h20;
  localparam logic [7:0] A_ADDR = 8'h24;
  localparam int unsigned CTRL_BASIC_BIT = 2;
  localparam int unsigned CTRL_POR_BIT = 3;
  // =====================================================================
  // types
  typedef enum logic [5:0] {
    ST_CMD = 6'h01, ST_ADDR = 6'h02, ST_DUMMY = 6'h04,
    ST_DIN = 6'h08, ST_OUT = 6'h10, ST_IGN = 6'h20
  } qxr_fsm_t;

  typedef struct packed {
    logic [2:0] sb_sync;
    logic [2:0] sc_sync;
    logic [3:0] dq_s1;
    logic [3:0] dq_s2;
    logic [1:0] wp_sync;
    qxr_fsm_t st;
    logic [7:0] opc;
    logic [23:0] shreg;
    logic [4:0] bitcnt;
    logic [2:0] lines;
    logic din_done;
    logic [3:0] dcnt;
    logic [15:0] obuf;
    logic [3:0] ocnt;
    logic [3:0] dq_out;
    logic [3:0] dq_oe;
    logic write_enable_latch;
    logic hwprot;
    logic fast_por;
    logic execute_in_place_mode;
    logic [2:0] xip_lines;
    logic [7:0] sr;
    logic [7:0] flag;
    logic [7:0] lock;
    logic [15:0] nvcfg;
    logic [7:0] vcfg;
    logic [7:0] evcfg;
    logic [7:0] rdata;
    logic [23:0] addr;
    logic [1:0] proto;
    logic basic;
    logic [1:0] resc_stage;
    logic [4:0] resc_cnt;
    logic resc_hi;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } qxr_state_t;

  function automatic logic [2:0] xip_lines_of(input logic [2:0] code);
    case (code)
      NV_XIP_SINGLE: xip_lines_of = 3'h1;
      NV_XIP_DUAL: xip_lines_of = 3'h2;
      NV_XIP_QUAD: xip_lines_of = 3'h4;
      default: xip_lines_of = 3'h0;
    endcase
  endfunction

  localparam logic [2:0] XIP_LINES_RST = xip_lines_of(NVCFG_RST[11:9]);
  localparam qxr_state_t QXR_RST = '{default: '0, sb_sync: 3'h7, sc_sync: 3'h0, st: ST_CMD,
    lines: 3'h1, sr: 8'h00, nvcfg: NVCFG_RST, vcfg: VCFG_RST, evcfg: EVCFG_RST,
    execute_in_place_mode: (XIP_LINES_RST != 3'h0), xip_lines: XIP_LINES_RST, fast_por: NVCFG_RST[NV_FPOR_BIT],
    wp_sync: 2'h3, resc_hi: 1'b1};
endpackage

//--- tb_qxr_flash_cmd.sv
// Purpose: bench for the register command block
// Assumes: host model speaks the quad protocol
// Notes: fixed seed
`timescale 1ns/100ps
module tb_qxr_flash_cmd;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pw = 1'b0, wp_b = 1'b1;
  logic [7:0] pa = 8'h0, dd, fl;
  logic [31:0] pwd = 32'h0, prd, q;
  logic prdy, perr, s_b, sclk, e;
  logic [3:0] hdq, dq, dqo, dqoe;
  logic [63:0] rx;
  logic [23:0] ad;
  logic [1:0] lk;
  int err_count = 0, total_checks = 0, seed = 32'h5b82;
  assign dq = (dqoe & dqo) | (~dqoe & hdq);
  qxr_flash_cmd dut (.I_CLK(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pw),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr), .I_S_B(s_b),
    .I_SCLK(sclk), .I_WP_B(wp_b), .I_DQ(dq), .O_DQ(dqo), .O_DQ_OE(dqoe));
  qxr_host_model h (.o_s_b(s_b), .o_sclk(sclk), .o_dq(hdq), .i_dq(dq));
  initial forever #4 clk = ~clk;
  // =====================================
  // tasks
  function automatic logic [7:0] clr_err(input logic [7:0] f);
    return f & 8'hc5;
  endfunction
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 40 && prdy !== 1'b1; k++) @(posedge clk);
    if (k == 40) begin
      err_count++;
      summarize();
    end
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, q & m);
  endtask
  task automatic wc(input logic [7:0] op, v);
    h.frame({op, v, 48'h0}, 4, 4, rx);
  endtask
  task automatic lr(input logic [63:0] t, input int ni, input logic [7:0] x);
    h.frame(t, ni + 8, ni, rx);
    chk("link data", {16'h0, x, x}, {16'h0, rx[15:0]});
  endtask
  task automatic rescue;
    h.frame('1, 7, 7, rx);
    h.frame('1, 13, 13, rx);
    h.frame('1, 25, 25, rx);
  endtask
  // =====================================
  // main sequence
  initial begin
    dd = 8'($random(seed));
    fl = 8'($random(seed));
    lk = 2'($random(seed));
    ad = 24'($random(seed));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h04, 32'h7f, 32'h0);
    rd(8'h18, 32'hff, 32'hfb);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    apb(1'b1, 8'h20, {24'h0, dd});
    apb(1'b1, 8'h00, 32'h2);
    wc(8'h42, 8'h80);
    rd(8'h08, 32'hff, 32'h0);
    wc(8'h4d, 8'h0);
    wc(8'h42, 8'h0c);
    rd(8'h08, 32'hff, 32'h0c);
    lr({8'h41, 56'h0}, 2, 8'h0c);
    apb(1'b1, 8'h0c, {24'h0, fl});
    wc(8'h4d, 8'h0);
    wc(8'h46, 8'h0);
    rd(8'h0c, 32'hff, {24'h0, clr_err(fl)});
    lr({8'h45, 56'h0}, 2, clr_err(fl));
    rd(8'h04, 32'h1, 32'h1);
    h.frame({8'h44, ad, 6'h0, lk, 24'h0}, 10, 10, rx);
    h.frame({8'h44, ad, 8'h0, 24'h0}, 10, 10, rx);
    rd(8'h10, 32'hff, {30'h0, lk});
    lr({8'h43, ad, 32'h0}, 8, {6'h0, lk});
    wc(8'h4d, 8'h0);
    h.frame({8'h48, 16'hf9ff, 40'h0}, 6, 6, rx);
    h.frame({8'h48, 16'h0000, 40'h0}, 6, 6, rx);
    rd(8'h14, 32'hffff, 32'hf9ff);
    rd(8'h04, 32'h3c, 32'h0);
    apb(1'b1, 8'h0c, {24'h0, fl});
    wc(8'h46, 8'h0);
    rd(8'h0c, 32'hff, {24'h0, clr_err(fl)});
    rd(8'h04, 32'h1, 32'h0);
    wc(8'h4a, 8'hf3);
    rd(8'h18, 32'hff, 32'hfb);
    apb(1'b1, 8'h00, 32'h6);
    lr({8'heb, ad, 32'h0}, 16, dd);
    rd(8'h04, 32'h4, 32'h4);
    ad = 24'($random(seed));
    lr({ad, 4'h1, 36'h0}, 14, dd);
    rd(8'h24, 32'hffffff, {8'h0, ad});
    rd(8'h04, 32'h4, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    wc(8'h4d, 8'h0);
    wc(8'h4a, 8'hf3);
    rd(8'h18, 32'hff, 32'hf3);
    lr({8'heb, ad, 4'he, 28'h0}, 16, dd);
    rd(8'h04, 32'h4, 32'h4);
    ad = 24'($random(seed));
    lr({ad, 4'he, 36'h0}, 14, dd);
    rd(8'h24, 32'hffffff, {8'h0, ad});
    rescue();
    rd(8'h04, 32'h4, 32'h0);
    rd(8'h18, 32'hff, 32'hf3);
    apb(1'b1, 8'h00, 32'ha);
    rd(8'h04, 32'h7c, 32'h64);
    rescue();
    wc(8'h4a, dd);
    rd(8'h18, 32'hff, {24'h0, dd});
    wc(8'h4c, fl);
    rd(8'h1c, 32'hff, {24'h0, fl});
    wc(8'h4d, 8'h0);
    rd(8'h04, 32'h40, 32'h0);
    wc(8'h42, 8'h80);
    rd(8'h04, 32'h2, 32'h2);
    apb(1'b1, 8'h00, 32'h0);
    rd(8'h04, 32'h2, 32'h0);
    wp_b <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h04, 32'h2, 32'h2);
    summarize();
  end
endmodule // tb_qxr_flash_cmd
